// ---- common/sarc_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef SARC_REGS_SVH
`define SARC_REGS_SVH
`define SARC_OFF_CTRL      12'h000
`define SARC_OFF_CFG       12'h004
`define SARC_OFF_PSEL      12'h008
`define SARC_OFF_NSEL      12'h00c
`define SARC_OFF_RESH      12'h010
`define SARC_OFF_RESL      12'h014
`define SARC_OFF_AUX       12'h018
`define SARC_CTRL_EN       7
`define SARC_CTRL_TM       6
`define SARC_CTRL_DONE     5
`define SARC_CTRL_BUSY     4
`define SARC_CTRL_CM_LO    0
`define SARC_CFG_SC_LO     3
`define SARC_CFG_LJST      2
`define SARC_AUX_IE        0
`define SARC_AUX_T2_16     1
`define SARC_AUX_T3_16     2
`define SARC_AUX_STBY      3
`define SARC_RST_CTRL      8'h00
`define SARC_RST_CFG       8'hf8
`define SARC_RST_SEL       5'h1f
`define SARC_RST_AUX       4'h0
`define SARC_NSEL_GND      5'h11
`define SARC_NSEL_VREF     5'h10
`define SARC_PSEL_TEMP     5'h10
`define SARC_PSEL_VDD      5'h11
`define SARC_TRACK_CLKS    2'd3
`define SARC_CONV_CLKS     4'd11
`define SARC_MIN_PERIOD_NS 5000
`define SARC_CLK_NS        20
`endif

// ---- common/sarc_pkg.sv ----
// Types shared by the converter control block
package sarc_pkg;
  typedef enum logic [2:0] {
    SARC_SRC_SW, SARC_SRC_T0, SARC_SRC_T2, SARC_SRC_T1, SARC_SRC_EXT, SARC_SRC_T3,
    SARC_SRC_R6, SARC_SRC_R7
  } sarc_src_t;
  typedef enum logic [1:0] {SARC_IDLE, SARC_TRACK, SARC_CONV, SARC_WAITEDGE} sarc_state_t;
endpackage : sarc_pkg

// ---- rtl/sarc_ctrl.sv ----
// Conversion control for a 10-bit successive-approximation converter, APB slave
`include "sarc_regs.svh"
module sarc_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tmr0_ovf,
  input  wire logic        tmr1_ovf,
  input  wire logic        tmr2_lo_ovf,
  input  wire logic        tmr2_hi_ovf,
  input  wire logic        tmr3_lo_ovf,
  input  wire logic        tmr3_hi_ovf,
  input  wire logic        external_start_strobe,
  input  wire logic        sar_bit_in,
  output logic             sar_powered,
  output logic             sar_track,
  output logic             sar_clk_pulse,
  output logic             sar_diff_mode,
  output logic      [15:0] sar_pos_onehot,
  output logic             sar_pos_temp,
  output logic             sar_pos_vdd,
  output logic      [15:0] sar_neg_onehot,
  output logic             sar_neg_vref,
  output logic             conv_irq
);
  import sarc_pkg::*;

  // Decoded access strobes
  logic        acc_wr;
  logic        acc_rd;
  assign acc_wr = psel & penable & pwrite;
  assign acc_rd = psel & penable & ~pwrite;

  // Software registers
  logic        conv_enable_q, conv_enable_d;
  logic        track_mode_select_q, track_mode_select_d;
  logic        conv_done_flag_q, conv_done_flag_d;
  logic [2:0]  start_source_sel_q, start_source_sel_d;
  logic [4:0]  conv_clock_divider_q, conv_clock_divider_d;
  logic        left_justify_sel_q, left_justify_sel_d;
  logic [4:0]  positive_input_code_q, positive_input_code_d;
  logic [4:0]  negative_input_code_q, negative_input_code_d;
  logic [7:0]  result_high_byte_q, result_high_byte_d;
  logic [7:0]  result_low_byte_q, result_low_byte_d;
  logic        irq_enable_q, irq_enable_d;
  logic        t2_16bit_q, t2_16bit_d;
  logic        t3_16bit_q, t3_16bit_d;
  logic        standby_q, standby_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;

  // Conversion engine state
  sarc_state_t state_q, state_d;
  logic [4:0]  div_cnt_q, div_cnt_d;
  logic        sclk_q, sclk_d;
  logic [3:0]  step_q, step_d;
  logic [9:0]  sar_q, sar_d;
  logic        busy_q, busy_d;
  logic        irq_q, irq_d;
  logic        sw_start_q, sw_start_d;

  // Strobe synchroniser; first stage read only by the second
  logic        strb_s1_q, strb_s2_q, strb_s3_q;
  logic        strb_rise;

  // Result formatting, used for both bytes
  function automatic logic [15:0] fmt_result(input logic [9:0] code, input logic diff,
                                            input logic ljst);
    logic [15:0] r;
    r = 16'h0000;
    if (ljst) begin
      r = {code, 6'h00};
    end else if (diff) begin
      r = {{6{code[9]}}, code};
    end else begin
      r = {6'h00, code};
    end
    return r;
  endfunction : fmt_result

  // Operand decode for register reads
  function automatic logic [31:0] rd_mux(input logic [11:0] a, input logic [7:0] ctrl,
                                        input logic [7:0] cfg, input logic [7:0] ps,
                                        input logic [7:0] ns, input logic [7:0] rh,
                                        input logic [7:0] rl, input logic [7:0] ax);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      `SARC_OFF_CTRL: v = {24'h0, ctrl};
      `SARC_OFF_CFG:  v = {24'h0, cfg};
      `SARC_OFF_PSEL: v = {24'h0, ps};
      `SARC_OFF_NSEL: v = {24'h0, ns};
      `SARC_OFF_RESH: v = {24'h0, rh};
      `SARC_OFF_RESL: v = {24'h0, rl};
      `SARC_OFF_AUX:  v = {24'h0, ax};
      default:        v = 32'h0000_0000;
    endcase
    return v;
  endfunction : rd_mux

  logic        mapped;
  assign mapped = (paddr == `SARC_OFF_CTRL) || (paddr == `SARC_OFF_CFG) ||
                  (paddr == `SARC_OFF_PSEL) || (paddr == `SARC_OFF_NSEL) ||
                  (paddr == `SARC_OFF_RESH) || (paddr == `SARC_OFF_RESL) ||
                  (paddr == `SARC_OFF_AUX);

  // Start-event selection and timer width choice
  logic        start_evt;
  logic        diff_mode;
  logic [15:0] fmt;
  logic        sample_en;
  logic        last_step;
  assign diff_mode = (negative_input_code_q != `SARC_NSEL_GND);
  assign strb_rise = strb_s2_q & ~strb_s3_q;
  assign last_step = (step_q == `SARC_CONV_CLKS - 4'd1);
  assign fmt       = fmt_result(sar_q, diff_mode, left_justify_sel_q);

  always_comb begin
    start_evt = 1'b0;
    unique case (sarc_src_t'(start_source_sel_q))
      SARC_SRC_SW:  start_evt = sw_start_q;
      SARC_SRC_T0:  start_evt = tmr0_ovf;
      SARC_SRC_T2:  start_evt = t2_16bit_q ? tmr2_hi_ovf : tmr2_lo_ovf;
      SARC_SRC_T1:  start_evt = tmr1_ovf;
      SARC_SRC_EXT: start_evt = strb_rise;
      SARC_SRC_T3:  start_evt = t3_16bit_q ? tmr3_hi_ovf : tmr3_lo_ovf;
      default:      start_evt = 1'b0;                             // Reserved codes start nothing
    endcase
  end

  // Conversion clock divider: one pulse every divider+1 system clocks
  always_comb begin
    div_cnt_d = div_cnt_q;
    sclk_d    = 1'b0;
    if (!conv_enable_q) begin
      div_cnt_d = 5'h00;
    end else if (div_cnt_q >= conv_clock_divider_q) begin
      div_cnt_d = 5'h00;
      sclk_d    = 1'b1;
    end else begin
      div_cnt_d = div_cnt_q + 5'h01;
    end
  end
  assign sample_en = sclk_q;

  // Track, convert and completion sequencing
  always_comb begin
    state_d = state_q;
    step_d  = step_q;
    sar_d   = sar_q;
    busy_d  = busy_q;
    irq_d   = 1'b0;
    unique case (state_q)
      SARC_IDLE: begin
        step_d = 4'h0;
        if (conv_enable_q && start_evt) begin
          busy_d  = 1'b1;
          state_d = track_mode_select_q ? SARC_TRACK : SARC_CONV;
        end else if (conv_enable_q && track_mode_select_q &&
                     sarc_src_t'(start_source_sel_q) == SARC_SRC_EXT) begin
          state_d = SARC_WAITEDGE;
        end
      end
      SARC_WAITEDGE: begin
        if (!conv_enable_q || !track_mode_select_q ||
            sarc_src_t'(start_source_sel_q) != SARC_SRC_EXT) begin
          state_d = SARC_IDLE;
        end else if (strb_rise) begin
          busy_d  = 1'b1;
          step_d  = 4'h0;
          state_d = SARC_CONV;
        end
      end
      SARC_TRACK: begin
        if (sample_en) begin
          step_d = step_q + 4'h1;
          if (step_q == {2'b00, `SARC_TRACK_CLKS} - 4'h1) begin
            step_d  = 4'h0;
            state_d = SARC_CONV;
          end
        end
      end
      SARC_CONV: begin
        if (sample_en) begin
          step_d = step_q + 4'h1;
          if (step_q == 4'h0) begin
            sar_d = 10'h000;
          end else begin
            sar_d = {sar_q[8:0], sar_bit_in};                     // Serial bits MSB first
          end
          if (last_step) begin
            busy_d  = 1'b0;
            irq_d   = irq_enable_q;
            state_d = SARC_IDLE;
          end
        end
      end
    endcase
    if (!conv_enable_q) begin
      state_d = SARC_IDLE;
      busy_d  = 1'b0;
    end
  end

  // Completion pulse taken from the busy falling edge
  logic        done_evt;
  assign done_evt = busy_q & ~busy_d & (state_q == SARC_CONV) & last_step & sample_en;

  // Register writes, result capture and bus answers
  always_comb begin
    conv_enable_d         = conv_enable_q;
    track_mode_select_d   = track_mode_select_q;
    conv_done_flag_d      = conv_done_flag_q;
    start_source_sel_d    = start_source_sel_q;
    conv_clock_divider_d  = conv_clock_divider_q;
    left_justify_sel_d    = left_justify_sel_q;
    positive_input_code_d = positive_input_code_q;
    negative_input_code_d = negative_input_code_q;
    result_high_byte_d    = result_high_byte_q;
    result_low_byte_d     = result_low_byte_q;
    irq_enable_d          = irq_enable_q;
    t2_16bit_d            = t2_16bit_q;
    t3_16bit_d            = t3_16bit_q;
    standby_d             = standby_q;
    sw_start_d            = 1'b0;
    pready_d              = 1'b0;
    pslverr_d             = 1'b0;
    prdata_d              = prdata_q;
    if (psel && !penable) begin
      // Answer one cycle after setup, so access phase is always one cycle
      pready_d  = 1'b1;
      pslverr_d = ~mapped;
      prdata_d  = rd_mux(paddr,
                    {conv_enable_q, track_mode_select_q, conv_done_flag_q, busy_q, 1'b0,
                     start_source_sel_q},
                    {conv_clock_divider_q, left_justify_sel_q, 2'b00},
                    {3'b000, positive_input_code_q}, {3'b000, negative_input_code_q},
                    result_high_byte_q, result_low_byte_q,
                    {4'h0, standby_q, t3_16bit_q, t2_16bit_q, irq_enable_q});
    end
    if (acc_wr && pready_q) begin
      unique case (paddr)
        `SARC_OFF_CTRL: begin
          conv_enable_d       = pwdata[`SARC_CTRL_EN];
          track_mode_select_d = pwdata[`SARC_CTRL_TM];
          if (!pwdata[`SARC_CTRL_DONE]) begin
            conv_done_flag_d = 1'b0;
          end
          start_source_sel_d  = pwdata[`SARC_CTRL_CM_LO +: 3];
          sw_start_d          = pwdata[`SARC_CTRL_BUSY] &
                                (pwdata[`SARC_CTRL_CM_LO +: 3] == 3'h0);
        end
        `SARC_OFF_CFG: begin
          conv_clock_divider_d = pwdata[`SARC_CFG_SC_LO +: 5];
          left_justify_sel_d   = pwdata[`SARC_CFG_LJST];
        end
        `SARC_OFF_PSEL: positive_input_code_d = pwdata[4:0];
        `SARC_OFF_NSEL: negative_input_code_d = pwdata[4:0];
        `SARC_OFF_AUX: begin
          irq_enable_d = pwdata[`SARC_AUX_IE];
          t2_16bit_d   = pwdata[`SARC_AUX_T2_16];
          t3_16bit_d   = pwdata[`SARC_AUX_T3_16];
          standby_d    = pwdata[`SARC_AUX_STBY];
        end
        default: begin
          // Result bytes and unmapped words ignore writes
        end
      endcase
    end
    // Hardware set wins over a same-cycle software clear
    if (conv_done_flag_q || done_evt) begin
      conv_done_flag_d = conv_done_flag_q & conv_done_flag_d | done_evt;
    end
  end

  // Result capture: formatted at the final conversion clock
  logic [9:0]  last_code;
  logic [15:0] fmt_new;
  assign last_code = {sar_q[8:0], sar_bit_in};
  assign fmt_new   = fmt_result(last_code, diff_mode, left_justify_sel_q);

  // Strobe synchroniser
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      strb_s1_q <= 1'b0;
      strb_s2_q <= 1'b0;
      strb_s3_q <= 1'b0;
    end else begin
      strb_s1_q <= external_start_strobe;
      strb_s2_q <= strb_s1_q;
      strb_s3_q <= strb_s2_q;
    end
  end

  // State registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      conv_enable_q         <= 1'(`SARC_RST_CTRL >> `SARC_CTRL_EN);
      track_mode_select_q   <= 1'b0;
      conv_done_flag_q      <= 1'b0;
      start_source_sel_q    <= 3'h0;
      conv_clock_divider_q  <= 5'(`SARC_RST_CFG >> `SARC_CFG_SC_LO);
      left_justify_sel_q    <= 1'b0;
      positive_input_code_q <= `SARC_RST_SEL;
      negative_input_code_q <= `SARC_RST_SEL;
      result_high_byte_q    <= 8'h00;
      result_low_byte_q     <= 8'h00;
      irq_enable_q          <= 1'b0;
      t2_16bit_q            <= 1'b0;
      t3_16bit_q            <= 1'b0;
      standby_q             <= 1'b0;
      prdata_q              <= 32'h0000_0000;
      pready_q              <= 1'b0;
      pslverr_q             <= 1'b0;
      state_q               <= SARC_IDLE;
      div_cnt_q             <= 5'h00;
      sclk_q                <= 1'b0;
      step_q                <= 4'h0;
      sar_q                 <= 10'h000;
      busy_q                <= 1'b0;
      irq_q                 <= 1'b0;
      sw_start_q            <= 1'b0;
    end else begin
      conv_enable_q         <= conv_enable_d;
      track_mode_select_q   <= track_mode_select_d;
      conv_done_flag_q      <= conv_done_flag_d;
      start_source_sel_q    <= start_source_sel_d;
      conv_clock_divider_q  <= conv_clock_divider_d;
      left_justify_sel_q    <= left_justify_sel_d;
      positive_input_code_q <= positive_input_code_d;
      negative_input_code_q <= negative_input_code_d;
      result_high_byte_q    <= done_evt ? fmt_new[15:8] : result_high_byte_d;
      result_low_byte_q     <= done_evt ? fmt_new[7:0] : result_low_byte_d;
      irq_enable_q          <= irq_enable_d;
      t2_16bit_q            <= t2_16bit_d;
      t3_16bit_q            <= t3_16bit_d;
      standby_q             <= standby_d;
      prdata_q              <= prdata_d;
      pready_q              <= pready_d;
      pslverr_q             <= pslverr_d;
      state_q               <= state_d;
      div_cnt_q             <= div_cnt_d;
      sclk_q                <= sclk_d;
      step_q                <= step_d;
      sar_q                 <= sar_d;
      busy_q                <= busy_d;
      irq_q                 <= irq_d;
      sw_start_q            <= sw_start_d;
    end
  end

  // Analog-side outputs, each from a flip-flop
  logic        trk_q;
  logic [15:0] pos_oh_q, neg_oh_q;
  logic [3:0]  misc_q;
  logic        trk_d;
  assign trk_d = conv_enable_q & ~standby_q &
                 ((state_d == SARC_IDLE && !track_mode_select_q) ||
                  state_d == SARC_TRACK ||
                  (state_d == SARC_WAITEDGE && !strb_s2_q));
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      trk_q    <= 1'b0;
      pos_oh_q <= 16'h0000;
      neg_oh_q <= 16'h0000;
      misc_q   <= 4'h0;
    end else begin
      trk_q    <= trk_d;
      pos_oh_q <= positive_input_code_q[4] ? 16'h0000 :
                  16'h0001 << positive_input_code_q[3:0];
      neg_oh_q <= negative_input_code_q[4] ? 16'h0000 :
                  16'h0001 << negative_input_code_q[3:0];
      misc_q   <= {positive_input_code_q == `SARC_PSEL_TEMP,
                   positive_input_code_q == `SARC_PSEL_VDD,
                   negative_input_code_q == `SARC_NSEL_VREF, diff_mode};
    end
  end

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign sar_powered    = conv_enable_q;
  assign sar_track      = trk_q;
  assign sar_clk_pulse  = sclk_q;
  assign sar_pos_onehot = pos_oh_q;
  assign sar_neg_onehot = neg_oh_q;
  assign sar_pos_temp   = misc_q[3];
  assign sar_pos_vdd    = misc_q[2];
  assign sar_neg_vref   = misc_q[1];
  assign sar_diff_mode  = misc_q[0];
  assign conv_irq       = irq_q;
endmodule : sarc_ctrl

// ---- testbench/sarc_core_model.sv ----
// Behavioural model of the analog comparator core
module sarc_core_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       sar_powered,
  input  wire logic       sar_track,
  input  wire logic       sar_clk_pulse,
  input  wire logic [9:0] code,
  output logic            sar_bit_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;  // Conversion clocks since tracking ended
  logic [3:0] cnt_d;
  logic       tgl_q;  // Filler that changes every cycle
  // Restart the count while tracking or powered down
  always_comb begin
    cnt_d = cnt_q;
    if (!sar_powered || sar_track) cnt_d = 4'h0;
    else if (sar_clk_pulse && cnt_q != 4'hf) cnt_d = cnt_q + 4'h1;
  end
  always_ff @(posedge sys_clk) begin
    cnt_q <= rst_b ? cnt_d : 4'h0;
    tgl_q <= rst_b ? !tgl_q : 1'b0;
  end
  // Decisions MSB first; a stale bit must never look right
  always_comb begin
    if (cnt_q >= 4'h1 && cnt_q <= 4'ha) sar_bit_in = code[4'ha - cnt_q];
    else sar_bit_in = tgl_q;
  end
endmodule : sarc_core_model

// ---- testbench/sarc_ctrl_monitor.sv ----
// Concurrent checks on the converter control ports
module sarc_ctrl_monitor (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sar_powered,
  input wire logic        sar_track,
  input wire logic        sar_clk_pulse,
  input wire logic        sar_diff_mode,
  input wire logic [15:0] sar_pos_onehot,
  input wire logic        sar_pos_temp,
  input wire logic        sar_pos_vdd,
  input wire logic [15:0] sar_neg_onehot,
  input wire logic        sar_neg_vref,
  input wire logic        conv_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [3:0] cnv_q;  // Conversion clocks since tracking ended
  logic [3:0] cnv_d;
  // Count pulses while the input is held
  always_comb begin
    cnv_d = cnv_q;
    if (sar_track || !sar_powered) cnv_d = 4'h0;
    else if (sar_clk_pulse && cnv_q != 4'hf) cnv_d = cnv_q + 4'h1;
  end
  always_ff @(posedge sys_clk) cnv_q <= rst_b ? cnv_d : 4'h0;
  // Bus setup, then exactly one ready cycle
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_answer;
    pready ##1 !pready;
  endsequence
  chk_ready_after_setup: assert property (apb_setup |=> apb_answer)
    else $error("no single ready after setup");
  chk_slverr_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_shutdown_idle: assert property (
    !sar_powered && !$past(sar_powered) |-> !sar_clk_pulse && !conv_irq)
    else $error("activity while shut down");
  chk_single_ended: assert property (
    !sar_diff_mode |-> sar_neg_onehot == 16'h0000 && !sar_neg_vref)
    else $error("single-ended with a live negative input");
  chk_pos_select: assert property (
    $onehot0({sar_pos_vdd, sar_pos_temp, sar_pos_onehot}))
    else $error("several positive inputs");
  chk_neg_select: assert property ($onehot0({sar_neg_vref, sar_neg_onehot}))
    else $error("several negative inputs");
  chk_irq_pulse: assert property (conv_irq |=> !conv_irq)
    else $error("completion request too long");
  chk_conv_length: assert property (conv_irq |-> cnv_q inside {4'ha, 4'hb})
    else $error("conversion clock count wrong");
endmodule : sarc_ctrl_monitor
bind sarc_ctrl sarc_ctrl_monitor u_mon (.sys_clk, .rst_b, .psel, .penable, .pready, .pslverr,
  .sar_powered, .sar_track, .sar_clk_pulse, .sar_diff_mode, .sar_pos_onehot, .sar_pos_temp,
  .sar_pos_vdd, .sar_neg_onehot, .sar_neg_vref, .conv_irq);

// ---- testbench/sarc_ctrl_bench.sv ----
// Self-checking bench for the converter control block
`include "sarc_regs.svh"
module sarc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sarc_pkg::*;
  logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, errq;
  logic        sar_powered, sar_track, sar_clk_pulse, sar_diff_mode, conv_irq, sar_bit_in;
  logic        sar_pos_temp, sar_pos_vdd, sar_neg_vref, external_start_strobe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdq;
  logic [15:0] sar_pos_onehot, sar_neg_onehot;
  logic [9:0]  code;
  logic [5:0]  ovf;  // t0, t1, t2 low, t2 high, t3 low, t3 high
  logic        win, seen, saw_lo, saw_hi, saw_irq;
  int          err_total, samples_checked, cyc, gap, div;
  // Conversion table: source, then mode bits by entry, then decision code
  sarc_src_t   src [8] = '{SARC_SRC_SW, SARC_SRC_SW, SARC_SRC_T0, SARC_SRC_T2,
                           SARC_SRC_T1, SARC_SRC_EXT, SARC_SRC_T3, SARC_SRC_EXT};
  logic [7:0]  tm = 8'h8a, lj = 8'h9a, df = 8'hec;
  logic [9:0]  cd [8] = '{10'h3ff, 10'h3ff, 10'h200, 10'h200, 10'h200, 10'h100, 10'h300, 10'h2ff};
  int          rt [6] = '{0, 0, 2, 1, 0, 5};  // Overflow that starts each source
  int          wr [6] = '{0, 1, 3, 0, 0, 4};  // Decoy that must not
  logic [7:0]  sel [5] = '{8'h00, 8'h0f, 8'h10, 8'h11, 8'hff};
  logic [31:0] rstv [7] = '{32'h0, 32'hf8, 32'h1f, 32'h1f, 32'h0, 32'h0, 32'h0};
  localparam logic [11:0] ctl_a = `SARC_OFF_CTRL;
  sarc_ctrl DUT (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tmr0_ovf(ovf[0]), .tmr1_ovf(ovf[1]), .tmr2_lo_ovf(ovf[2]), .tmr2_hi_ovf(ovf[3]),
    .tmr3_lo_ovf(ovf[4]), .tmr3_hi_ovf(ovf[5]), .external_start_strobe, .sar_bit_in,
    .sar_powered, .sar_track, .sar_clk_pulse, .sar_diff_mode, .sar_pos_onehot, .sar_pos_temp,
    .sar_pos_vdd, .sar_neg_onehot, .sar_neg_vref, .conv_irq);
  sarc_core_model CORE (.sys_clk, .rst_b, .sar_powered, .sar_track, .sar_clk_pulse, .code,
    .sar_bit_in);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // One transfer; held until ready is seen at an edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk) penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rdq = prdata;
    errq = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic pulse(input int k);
    ovf[k] <= 1'b1;
    @(posedge sys_clk) ovf <= 6'h00;
    @(posedge sys_clk);
  endtask : pulse
  // One conversion from entry i, checked end to end
  task automatic run(input int i);
    logic [7:0]  ctl;
    logic [15:0] e;
    int          n;
    ctl = {1'b1, tm[i], 3'b000, src[i]};
    e = lj[i] ? {cd[i], 6'h00} : {{6{df[i] & cd[i][9]}}, cd[i]};
    code = cd[i];
    div = i;
    bus(1'b1, `SARC_OFF_CFG, {5'(i), lj[i], 2'b00});
    bus(1'b1, `SARC_OFF_NSEL, df[i] ? 8'h10 : 8'h11);
    bus(1'b1, ctl_a, ctl);
    repeat (3) @(posedge sys_clk);
    if (!tm[i]) cmp(32'(sar_track), 32'h1);
    {seen, saw_lo, saw_hi, saw_irq, win} = 5'b00001;
    case (src[i])
      SARC_SRC_SW: bus(1'b1, ctl_a, ctl | 8'h10);
      SARC_SRC_EXT: begin
        external_start_strobe <= 1'b1;
        repeat (4) @(posedge sys_clk);
      end
      default: begin
        pulse(wr[src[i]]);
        bus(1'b0, ctl_a, 8'h00);
        cmp(32'(rdq[4]), 32'h0);
        pulse(rt[src[i]]);
      end
    endcase
    bus(1'b0, ctl_a, 8'h00);
    cmp(32'(rdq[5:4]), 32'h1);
    n = 0;
    while (!rdq[5] && n < 400) begin
      bus(1'b0, ctl_a, 8'h00);
      n++;
    end
    win = 1'b0;
    cmp(rdq, 32'(ctl | 8'h20));
    cmp(32'({saw_irq, saw_lo}), 32'h3);
    if (tm[i] && src[i] != SARC_SRC_EXT) cmp(32'(saw_hi), 32'h1);
    bus(1'b0, `SARC_OFF_RESH, 8'h00);
    cmp(rdq, 32'(e[15:8]));
    bus(1'b0, `SARC_OFF_RESL, 8'h00);
    cmp(rdq, 32'(e[7:0]));
    bus(1'b0, ctl_a, 8'h00);
    cmp(32'(rdq[5]), 32'h1);
    external_start_strobe <= 1'b0;
    @(posedge sys_clk);
  endtask : run
  // Conversion clock spacing, tracking and completion within a conversion
  always @(posedge sys_clk) begin
    if (win) begin
      if (sar_clk_pulse) begin
        if (seen) cmp(32'(gap), 32'(div + 1));
        seen = 1'b1;
        gap = 1;
      end else gap++;
      if (sar_track) saw_hi = 1'b1;
      else saw_lo = 1'b1;
      if (conv_irq) saw_irq = 1'b1;
    end
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    {rst_b, psel, penable, pwrite, external_start_strobe, win} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    ovf = 6'h00;
    code = 10'h000;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, 12'(4 * i), 8'h00);
      cmp(rdq, rstv[i]);
    end
    bus(1'b0, 12'h01c, 8'h00);
    cmp({rdq[30:0], errq}, 32'h1);
    // A start while disabled is dropped
    bus(1'b1, ctl_a, 8'h10);
    bus(1'b0, ctl_a, 8'h00);
    cmp(rdq, 32'h0);
    bus(1'b1, ctl_a, 8'h80);
    foreach (sel[j]) begin
      bus(1'b1, `SARC_OFF_PSEL, sel[j]);
      bus(1'b1, `SARC_OFF_NSEL, sel[j]);
      bus(1'b0, `SARC_OFF_PSEL, 8'h00);
      cmp(rdq, 32'(sel[j][4:0]));
      repeat (2) @(posedge sys_clk);
      cmp(32'({sar_pos_vdd, sar_pos_temp, sar_pos_onehot}),
          sel[j][4:0] < 5'h12 ? 32'h1 << sel[j][4:0] : 32'h0);
      cmp(32'({sar_neg_vref, sar_neg_onehot}),
          sel[j][4:0] < 5'h11 ? 32'h1 << sel[j][4:0] : 32'h0);
      cmp(32'(sar_diff_mode), 32'(sel[j][4:0] != 5'h11));
    end
    bus(1'b1, `SARC_OFF_AUX, 8'h05);
    for (int i = 0; i < 8; i++) run(i);
    bus(1'b1, ctl_a, 8'h80);
    bus(1'b0, ctl_a, 8'h00);
    cmp(rdq, 32'h80);
    // Standby stops tracking even in the default mode
    bus(1'b1, `SARC_OFF_AUX, 8'h0d);
    repeat (2) @(posedge sys_clk);
    cmp(32'(sar_track), 32'h0);
    stop_test();
  end
endmodule : sarc_ctrl_bench
